/* gq_pkg.sv */
// Purpose: shared constants and carrier types for the gpio input qualifier
// Assumes: 32-bit AHB-Lite register slave, one system clock
// Notes:   field layouts are flat vectors indexed by pin, group or slot
`default_nettype none
package gq_pkg;
    localparam int GQ_NPINS = 16;
    localparam int GQ_GRPW  = 8;
    localparam int GQ_NGRP  = GQ_NPINS / GQ_GRPW;
    localparam int GQ_DIVW  = 8;
    localparam int GQ_CNTW  = GQ_DIVW + 1;
    localparam int GQ_NXOUT = 3;
    localparam int GQ_NXSRC = 16;
    localparam int GQ_SRCW  = 4;
    localparam int GQ_NXIN  = 4;
    localparam int GQ_PINW  = 4;
    localparam int GQ_MUXW  = 2;
    localparam int GQ_QMW   = 2;
    localparam int GQ_HISTW = 6;
    localparam int GQ_AW    = 8;
    localparam int GQ_DW    = 32;
    localparam int GQ_SYNCW = 2;

    localparam logic [GQ_QMW-1:0] GQ_QM_SYNC  = 2'h0;
    localparam logic [GQ_QMW-1:0] GQ_QM_SAMP3 = 2'h1;
    localparam logic [GQ_QMW-1:0] GQ_QM_SAMP6 = 2'h2;
    localparam int                GQ_NSAMP3   = 3;
    localparam int                GQ_NSAMP6   = 6;

    localparam logic [GQ_AW-1:0] GQ_OFF_DIR  = 8'h00;
    localparam logic [GQ_AW-1:0] GQ_OFF_DOUT = 8'h04;
    localparam logic [GQ_AW-1:0] GQ_OFF_DIN  = 8'h08;
    localparam logic [GQ_AW-1:0] GQ_OFF_QSEL = 8'h0C;
    localparam logic [GQ_AW-1:0] GQ_OFF_CTRL = 8'h10;
    localparam logic [GQ_AW-1:0] GQ_OFF_MUX  = 8'h14;
    localparam logic [GQ_AW-1:0] GQ_OFF_XOUT = 8'h18;
    localparam logic [GQ_AW-1:0] GQ_OFF_XIN  = 8'h1C;

    localparam int GQ_HTRANS_ACT = 1;

    typedef struct packed {
        logic             valid;
        logic             write;
        logic [GQ_AW-1:0] addr;
    } gq_ahb_ap_t;

    typedef struct packed {
        logic                         ready;
        logic                         resp;
        gq_ahb_ap_t                   ap;
        logic [GQ_DW-1:0]             rdata;
        logic [GQ_NPINS-1:0]          dir;
        logic [GQ_NPINS-1:0]          dout;
        logic [GQ_NPINS-1:0]          pinOut;
        logic [GQ_NPINS-1:0]          pinOe;
        logic [GQ_NPINS*GQ_QMW-1:0]   qsel;
        logic [GQ_NGRP*GQ_DIVW-1:0]   div;
        logic [GQ_NPINS*GQ_MUXW-1:0]  mux;
        logic [GQ_NXOUT*GQ_SRCW-1:0]  xsrc;
        logic [GQ_NXIN*GQ_PINW-1:0]   xsel;
        logic [GQ_NXIN-1:0]           xin;
        logic [GQ_NGRP*GQ_CNTW-1:0]   cnt;
    } gq_state_t;

    localparam gq_state_t GQ_STATE_RST = '{ready: 1'b1, default: '0};
endpackage
`default_nettype wire

/* gq_sync.sv */
// Purpose: two-stage synchroniser for the raw pin levels
// Assumes: pins change with no relation to mclk
// Notes:   stage one feeds stage two only
`default_nettype none
module gq_sync
    import gq_pkg::*;
#(
    parameter int W = GQ_NPINS
) (
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } gq_sync_st_t;

    gq_sync_st_t st_r;
    gq_sync_st_t st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = din;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.s2;

    property p_sync_delay;
        @(posedge mclk) disable iff (!rst_b)
        $past(rst_b, GQ_SYNCW) |-> dout == $past(din, GQ_SYNCW);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("synchroniser delay wrong");
endmodule
`default_nettype wire

/* gq_qualifier.sv */
// Purpose: per-pin sample history filter, sync / 3-sample / 6-sample
// Assumes: sampleIn already synchronised, tick one cycle per sample
// Notes:   output holds until all samples of the window agree
`default_nettype none
module gq_qualifier
    import gq_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              sampleIn,
    input  wire logic              tick,
    input  wire logic [GQ_QMW-1:0] mode,
    output logic                   qualOut
);
    typedef struct packed {
        logic [GQ_HISTW-1:0] hist;
        logic                out;
    } gq_qual_st_t;

    gq_qual_st_t st_r;
    gq_qual_st_t st_nxt;

    function automatic logic agree(input logic [GQ_HISTW-1:0] h, input int n);
        logic all1;
        logic all0;
        all1 = 1'b1;
        all0 = 1'b1;
        for (int i = 0; i < GQ_HISTW; i++) begin
            if (i < n) begin
                all1 &= h[i];
                all0 &= ~h[i];
            end
        end
        return all1 | all0;
    endfunction

    always_comb begin
        st_nxt = st_r;
        if (tick) begin
            st_nxt.hist = {st_r.hist[GQ_HISTW-2:0], sampleIn};
        end
        unique case (mode)
            GQ_QM_SAMP3: begin
                if (tick && agree(st_nxt.hist, GQ_NSAMP3)) begin
                    st_nxt.out = st_nxt.hist[0];
                end
            end
            GQ_QM_SAMP6: begin
                if (tick && agree(st_nxt.hist, GQ_NSAMP6)) begin
                    st_nxt.out = st_nxt.hist[0];
                end
            end
            // code 3 is unassigned: treated as plain synchronous
            default: st_nxt.out = sampleIn;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign qualOut = st_r.out;

    property p_q3_agree;
        @(posedge mclk) disable iff (!rst_b)
        (mode == GQ_QM_SAMP3 && $changed(st_r.out) && $past(mode) == GQ_QM_SAMP3)
            |-> st_r.hist[GQ_NSAMP3-1:0] == {GQ_NSAMP3{st_r.out}};
    endproperty
    a_q3_agree: assert property (p_q3_agree) else $error("3-sample change w/o agreement");

    property p_q6_agree;
        @(posedge mclk) disable iff (!rst_b)
        (mode == GQ_QM_SAMP6 && $changed(st_r.out) && $past(mode) == GQ_QM_SAMP6)
            |-> st_r.hist == {GQ_NSAMP6{st_r.out}};
    endproperty
    a_q6_agree: assert property (p_q6_agree) else $error("6-sample change w/o agreement");

    property p_q3_pass;
        @(posedge mclk) disable iff (!rst_b)
        (mode == GQ_QM_SAMP3 && tick && sampleIn)[*3] |=> st_r.out;
    endproperty
    a_q3_pass: assert property (p_q3_pass) else $error("3 high samples not accepted");

    property p_q6_pass;
        @(posedge mclk) disable iff (!rst_b)
        (mode == GQ_QM_SAMP6 && tick && !sampleIn)[*6] |=> !st_r.out;
    endproperty
    a_q6_pass: assert property (p_q6_pass) else $error("6 low samples not accepted");
endmodule
`default_nettype wire

/* gq_top.sv */
// Purpose: gpio input qualifier with output and input crossbars, AHB-Lite registers
// Assumes: single word transfers, zero wait states, mclk is the system clock
// Notes:   hrdata is prepared in the address phase so that it comes from a flop
`default_nettype none
// How it works
// - after reset every pin is an input and no output enable is asserted.
// - a group divider of zero samples the pin on every clock.
// - a nonzero divider n takes one sample every 2n clocks.
// - the divider is eight bits and takes any value up to 0xFF.
// - one divider serves each group of eight consecutive pins.
// - each pin selects three-sample or six-sample qualification.
// - the three-sample window spans two sampling periods.
// - the six-sample window spans five sampling periods.
// - the window length is the period times the sample count minus one.
// - a level change shows only when every sample of the window agrees.
// - pins may be driven by crossbar slots through their function multiplexer.
// - the input crossbar routes any qualified pin to an internal consumer.
module gq_top
    import gq_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                rst_b,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [GQ_DW-1:0]    hwdata,
    input  wire logic                hready,
    output logic      [GQ_DW-1:0]    hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic [GQ_NPINS-1:0] pinIn,
    output logic      [GQ_NPINS-1:0] pinOut,
    output logic      [GQ_NPINS-1:0] pinOe,
    input  wire logic [GQ_NXSRC-1:0] xoutSrc,
    output logic      [GQ_NXIN-1:0]  xinOut
);
    gq_state_t           st_r;
    gq_state_t           st_nxt;
    logic [GQ_NPINS-1:0] pinSync;
    logic [GQ_NPINS-1:0] qualVec;
    logic [GQ_NGRP-1:0]  tick;
    logic [GQ_NXOUT-1:0] slotVal;

    gq_sync #(
        .W(GQ_NPINS)
    ) u_sync (
        .mclk (mclk),
        .rst_b(rst_b),
        .din  (pinIn),
        .dout (pinSync)
    );

    // sampling period divider: counter per group, compare against 2n-1
    function automatic logic [GQ_CNTW-1:0] tick_limit(input logic [GQ_DIVW-1:0] d);
        return {d, 1'b0} - GQ_CNTW'(1);
    endfunction

    always_comb begin
        for (int g = 0; g < GQ_NGRP; g++) begin
            tick[g] = (st_r.div[g*GQ_DIVW +: GQ_DIVW] == '0) ||
                      (st_r.cnt[g*GQ_CNTW +: GQ_CNTW] >=
                       tick_limit(st_r.div[g*GQ_DIVW +: GQ_DIVW]));
        end
    end

    generate
        for (genvar p = 0; p < GQ_NPINS; p++) begin : g_qual
            gq_qualifier u_qual (
                .mclk    (mclk),
                .rst_b   (rst_b),
                .sampleIn(pinSync[p]),
                .tick    (tick[p / GQ_GRPW]),
                .mode    (st_r.qsel[p*GQ_QMW +: GQ_QMW]),
                .qualOut (qualVec[p])
            );
        end
        for (genvar k = 0; k < GQ_NXOUT; k++) begin : g_slot
            assign slotVal[k] = xoutSrc[st_r.xsrc[k*GQ_SRCW +: GQ_SRCW]];
        end
    endgenerate

    function automatic logic [GQ_DW-1:0] read_reg(input gq_state_t s,
                                                  input logic [GQ_AW-1:0] a,
                                                  input logic [GQ_NPINS-1:0] q);
        logic [GQ_DW-1:0] r;
        r = '0;
        unique case (a)
            GQ_OFF_DIR:  r = GQ_DW'(s.dir);
            GQ_OFF_DOUT: r = GQ_DW'(s.dout);
            GQ_OFF_DIN:  r = GQ_DW'(q);
            GQ_OFF_QSEL: r = GQ_DW'(s.qsel);
            GQ_OFF_CTRL: r = GQ_DW'(s.div);
            GQ_OFF_MUX:  r = GQ_DW'(s.mux);
            GQ_OFF_XOUT: r = GQ_DW'(s.xsrc);
            GQ_OFF_XIN:  r = GQ_DW'(s.xsel);
            default:     r = '0;
        endcase
        return r;
    endfunction

    always_comb begin
        logic [GQ_MUXW-1:0] m;
        m      = '0;
        st_nxt = st_r;
        st_nxt.ready = 1'b1;
        st_nxt.resp  = 1'b0;

        for (int g = 0; g < GQ_NGRP; g++) begin
            if (tick[g]) begin
                st_nxt.cnt[g*GQ_CNTW +: GQ_CNTW] = '0;
            end else begin
                st_nxt.cnt[g*GQ_CNTW +: GQ_CNTW] =
                    st_r.cnt[g*GQ_CNTW +: GQ_CNTW] + GQ_CNTW'(1);
            end
        end

        // data phase of a write; unmapped offsets are ignored, answer stays OKAY
        if (st_r.ap.valid && st_r.ap.write) begin
            unique case (st_r.ap.addr)
                GQ_OFF_DIR:  st_nxt.dir  = hwdata[GQ_NPINS-1:0];
                GQ_OFF_DOUT: st_nxt.dout = hwdata[GQ_NPINS-1:0];
                GQ_OFF_QSEL: st_nxt.qsel = hwdata[GQ_NPINS*GQ_QMW-1:0];
                GQ_OFF_CTRL: st_nxt.div  = hwdata[GQ_NGRP*GQ_DIVW-1:0];
                GQ_OFF_MUX:  st_nxt.mux  = hwdata[GQ_NPINS*GQ_MUXW-1:0];
                GQ_OFF_XOUT: st_nxt.xsrc = hwdata[GQ_NXOUT*GQ_SRCW-1:0];
                GQ_OFF_XIN:  st_nxt.xsel = hwdata[GQ_NXIN*GQ_PINW-1:0];
                default:     st_nxt.dir  = st_r.dir;
            endcase
        end

        st_nxt.ap.valid = hsel && htrans[GQ_HTRANS_ACT] && hready;
        st_nxt.ap.write = hwrite;
        st_nxt.ap.addr  = haddr[GQ_AW-1:0];
        // read from the updated copy so a read right after a write sees it
        if (st_nxt.ap.valid && !hwrite) begin
            st_nxt.rdata = read_reg(st_nxt, haddr[GQ_AW-1:0], qualVec);
        end

        for (int p = 0; p < GQ_NPINS; p++) begin
            m = st_r.mux[p*GQ_MUXW +: GQ_MUXW];
            if (m == '0) begin
                st_nxt.pinOut[p] = st_r.dout[p];
            end else begin
                st_nxt.pinOut[p] = slotVal[m - GQ_MUXW'(1)];
            end
        end
        st_nxt.pinOe = st_r.dir;

        for (int c = 0; c < GQ_NXIN; c++) begin
            st_nxt.xin[c] = qualVec[st_r.xsel[c*GQ_PINW +: GQ_PINW]];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= GQ_STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hrdata    = st_r.rdata;
    assign hreadyout = st_r.ready;
    assign hresp     = st_r.resp;
    assign pinOut    = st_r.pinOut;
    assign pinOe     = st_r.pinOe;
    assign xinOut    = st_r.xin;

    // checking helpers
    logic                dirWritten;
    logic [GQ_CNTW-1:0]  gapCnt;
    logic                haveRef;
    logic [GQ_DIVW-1:0]  divPrev;
    logic [GQ_NPINS-1:0] qualPrev;
    logic [GQ_PINW-1:0]  selPrev;
    logic                wrData;
    logic                wrCtrl;

    assign wrData = st_r.ap.valid && st_r.ap.write;
    assign wrCtrl = wrData && st_r.ap.addr == GQ_OFF_CTRL;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dirWritten <= 1'b0;
            gapCnt     <= '0;
            haveRef    <= 1'b0;
            divPrev    <= '0;
            qualPrev   <= '0;
            selPrev    <= '0;
        end else begin
            if (wrData && st_r.ap.addr == GQ_OFF_DIR) begin
                dirWritten <= 1'b1;
            end
            gapCnt   <= tick[0] ? GQ_CNTW'(1) : gapCnt + GQ_CNTW'(1);
            haveRef  <= tick[0] || (haveRef && st_r.div[GQ_DIVW-1:0] == divPrev);
            divPrev  <= st_r.div[GQ_DIVW-1:0];
            qualPrev <= qualVec;
            selPrev  <= st_r.xsel[GQ_PINW-1:0];
        end
    end

    property p_reset_input;
        @(posedge mclk) disable iff (!rst_b)
        !dirWritten |-> pinOe == '0;
    endproperty
    a_reset_input: assert property (p_reset_input) else $error("pin driven before setup");

    property p_tick_every;
        @(posedge mclk) disable iff (!rst_b)
        st_r.div[GQ_DIVW-1:0] == '0 |-> tick[0];
    endproperty
    a_tick_every: assert property (p_tick_every) else $error("zero divider missed a sample");

    property p_tick_gap;
        @(posedge mclk) disable iff (!rst_b)
        (tick[0] && haveRef && st_r.div[GQ_DIVW-1:0] == divPrev && divPrev != '0)
            |-> gapCnt == {divPrev, 1'b0};
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("sample spacing is not 2n");

    property p_div_write;
        @(posedge mclk) disable iff (!rst_b)
        wrCtrl |=> st_r.div == $past(hwdata[GQ_NGRP*GQ_DIVW-1:0]);
    endproperty
    a_div_write: assert property (p_div_write) else $error("divider write lost");

    property p_xout;
        @(posedge mclk) disable iff (!rst_b)
        (st_r.mux[GQ_MUXW-1:0] == GQ_MUXW'(1)) |=> pinOut[0] == $past(slotVal[0]);
    endproperty
    a_xout: assert property (p_xout) else $error("crossbar slot not on pin");

    property p_xin;
        @(posedge mclk) disable iff (!rst_b)
        xinOut[0] == qualPrev[selPrev];
    endproperty
    a_xin: assert property (p_xin) else $error("input crossbar routed wrong pin");

    c_slow_tick: cover property (@(posedge mclk) disable iff (!rst_b)
        tick[0] && haveRef && divPrev > GQ_DIVW'(1));
    c_qual_rise: cover property (@(posedge mclk) disable iff (!rst_b) $rose(qualVec[0]));
    c_pin_drive: cover property (@(posedge mclk) disable iff (!rst_b) $rose(pinOe[0]));
endmodule
`default_nettype wire

/* gq_pin_src.sv */
// Purpose: far-side model of the asynchronous sources that drive the pins
// Assumes: the bench commands each level and holds it two clocks or more
// Notes:   edges land mid-cycle so the synchroniser sees truly unrelated timing
`default_nettype none
module gq_pin_src
    import gq_pkg::*;
(
    input  wire logic [GQ_NPINS-1:0] lvl,
    output var  logic [GQ_NPINS-1:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;

    initial pins = '0;

    // offset from mclk so no edge coincides with a sampling edge
    always @(lvl) pins <= #37 lvl;
endmodule
`default_nettype wire

/* gpio_input_qualifier_tb.sv */
// Purpose: self-checking bench for the gpio input qualifier
// Assumes: zero wait-state AHB-Lite slave, 10 MHz mclk
// Notes:   glitch acceptance is seen on the input crossbar outputs every cycle
`default_nettype none
module gpio_input_qualifier_tb;
    import gq_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic                mclk;
    logic                rst_b;
    logic                hsel;
    logic [31:0]         haddr;
    logic [1:0]          htrans;
    logic                hwrite;
    logic [2:0]          hsize;
    logic [GQ_DW-1:0]    hwdata;
    logic [GQ_DW-1:0]    hrdata;
    logic                hreadyout;
    logic                hresp;
    logic [GQ_NPINS-1:0] pinIn;
    logic [GQ_NPINS-1:0] pinOut;
    logic [GQ_NPINS-1:0] pinOe;
    logic [GQ_NPINS-1:0] srcPins;
    logic [GQ_NPINS-1:0] lvl;
    logic [GQ_NXSRC-1:0] xoutSrc;
    logic [GQ_NXIN-1:0]  xinOut;
    logic [1:0]          dip;
    int                  n_mismatch;
    int                  checked;

    // wire level: the block wins where it drives, the source elsewhere
    assign pinIn = (pinOe & pinOut) | (~pinOe & srcPins);

    gq_top dut_u (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .xoutSrc(xoutSrc), .xinOut(xinOut));

    gq_pin_src src_u (.lvl(lvl), .pins(srcPins));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // any cycle where a watched consumer is not high marks a dip
    always @(posedge mclk) begin
        if (xinOut[0] !== 1'b1) dip[0] <= 1'b1;
        if (xinOut[1] !== 1'b1) dip[1] <= 1'b1;
    end

    task automatic results();
        $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: word got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: flag got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic ahbWr(input logic [GQ_AW-1:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= 1'b1;
        haddr <= {24'h000000, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
    endtask

    task automatic ahbRd(input logic [GQ_AW-1:0] a, output logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= 1'b0;
        haddr <= {24'h000000, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask

    // pins 0 and 8 go low for len cycles from a qualified high level
    task automatic glitch(input logic [31:0] ctrl, input logic [1:0] m, input int len,
                          output logic d0, output logic d8);
        logic [31:0] rd;
        ahbWr(GQ_OFF_CTRL, ctrl);
        ahbWr(GQ_OFF_QSEL, {14'h0000, m, 14'h0000, m});
        repeat (40) @(posedge mclk);
        dip = 2'b00;
        lvl <= 16'hFEFE;
        repeat (len) @(posedge mclk);
        lvl <= 16'hFFFF;
        repeat (60) @(posedge mclk);
        d0 = dip[0];
        d8 = dip[1];
        ahbRd(GQ_OFF_DIN, rd);
        chkWord(rd & 32'h00000101, 32'h00000101);
    endtask

    task automatic tReset();
        logic [31:0] rd;
        chkWord({16'h0000, pinOe}, 32'h00000000);
        ahbRd(GQ_OFF_DIR, rd);
        chkWord(rd, 32'h00000000);
        ahbWr(GQ_OFF_XIN, 32'h00000080);
        lvl <= 16'hFFFF;
    endtask

    task automatic tOutput();
        ahbWr(GQ_OFF_DIR, 32'h00000006);
        ahbWr(GQ_OFF_DOUT, 32'h00000002);
        ahbWr(GQ_OFF_XOUT, 32'h00000003);
        ahbWr(GQ_OFF_MUX, 32'h00000010);
        xoutSrc <= 16'h0008;
        repeat (3) @(posedge mclk);
        chkWord({16'h0000, pinOe}, 32'h00000006);
        chkWord({30'h0, pinOut[2:1]}, 32'h00000003);
        xoutSrc <= 16'h0000;
        repeat (3) @(posedge mclk);
        chkBit(pinOut[2], 1'b0);
        // slots 1 and 2 take sources 5 and 10; pin 1 on code 3, pin 2 on code 2
        ahbWr(GQ_OFF_XOUT, 32'h00000A53);
        ahbWr(GQ_OFF_MUX, 32'h0000002C);
        xoutSrc <= 16'h0400;
        repeat (3) @(posedge mclk);
        chkWord({30'h0, pinOut[2:1]}, 32'h00000001);
        xoutSrc <= 16'h0020;
        repeat (3) @(posedge mclk);
        chkWord({30'h0, pinOut[2:1]}, 32'h00000002);
    endtask

    task automatic tRegs();
        logic [31:0] rd;
        ahbWr(GQ_OFF_CTRL, 32'h0000FFFF);
        ahbRd(GQ_OFF_CTRL, rd);
        chkWord(rd, 32'h0000FFFF);
        ahbRd(8'h20, rd);
        chkWord(rd, 32'h00000000);
        chkBit(hresp, 1'b0);
    endtask

    task automatic tThreeSample();
        logic d0;
        logic d8;
        glitch(32'h00000000, GQ_QM_SAMP3, 2, d0, d8);
        chkBit(d0, 1'b0);
        glitch(32'h00000000, GQ_QM_SAMP3, 4, d0, d8);
        chkBit(d0, 1'b1);
        chkBit(d8, 1'b1);
    endtask

    task automatic tSixSample();
        logic d0;
        logic d8;
        glitch(32'h00000000, GQ_QM_SAMP6, 4, d0, d8);
        chkBit(d0, 1'b0);
        glitch(32'h00000000, GQ_QM_SAMP6, 7, d0, d8);
        chkBit(d0, 1'b1);
    endtask

    task automatic tSyncMode();
        logic d0;
        logic d8;
        glitch(32'h00000000, GQ_QM_SYNC, 2, d0, d8);
        chkBit(d0, 1'b1);
        chkBit(d8, 1'b1);
        // the unassigned selection code must behave as plain synchronous
        glitch(32'h00000000, 2'h3, 2, d0, d8);
        chkBit(d0, 1'b1);
    endtask

    task automatic tDivider();
        logic d0;
        logic d8;
        glitch(32'h00000002, GQ_QM_SAMP3, 6, d0, d8);
        chkBit(d0, 1'b0);
        chkBit(d8, 1'b1);
        glitch(32'h00000002, GQ_QM_SAMP3, 14, d0, d8);
        chkBit(d0, 1'b1);
        glitch(32'h00000200, GQ_QM_SAMP3, 6, d0, d8);
        chkBit(d0, 1'b1);
        chkBit(d8, 1'b0);
    endtask

    initial begin
        n_mismatch = 0;
        checked = 0;
        dip = 2'b00;
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        lvl = '0;
        xoutSrc = '0;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        tReset();
        tOutput();
        tRegs();
        tThreeSample();
        tSixSample();
        tSyncMode();
        tDivider();
        results();
    end

    // the whole sequence needs about eleven hundred cycles
    initial begin
        repeat (6000) @(posedge mclk);
        n_mismatch++;
        $display("ERROR at %0t: run did not finish in time", $time);
        results();
    end
endmodule
`default_nettype wire
